// ---- pemd_top.sv ----
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// [RULE_01] Software keeps bits eleven and ten zero.
// [RULE_02] Flag enable reserved without needed capabilities.
// [RULE_03] Flag enable bit turns second-level flags on.
// [RULE_04] Enables ignored for first-level and pass-through.
// [RULE_05] Type one selects first-level translation.
// [RULE_06] Type two selects second-level translation.
// [RULE_07] Type three selects nested translation.
// [RULE_08] Type four bypasses; other codes reserved.
// [RULE_09] Execute enable honours leaf execute flag.
// [RULE_10] Width codes give 39, 48, 57 bits.
// [RULE_11] Width zero and high codes reserved; the code flags zero only when second level is supported.
// [RULE_12] Software programs only supported widths.
// [RULE_13] Addresses beyond width fault under second level.
// [RULE_14] Fault disable suppresses fault reporting.
// [RULE_15] Fault disable evaluated even when absent.
// [RULE_16] Clear present bit makes entry absent.
// [RULE_17] Pointer bits above host width reserved.
// [RULE_18] Reserved type or width faults the entry.
module pemd_top (
	input logic clk_i,
	input logic rst_i,
	input logic ce_i,
	input logic cyc_i,
	input logic stb_i,
	input logic we_i,
	input logic [7:0] adr_i,
	input logic [3:0] sel_i,
	input logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic fault_report_o,
	output logic walk_start_o,
	output logic [51:0] walk_root_o
);
	// =================================================================
	// State.
	// =================================================================
	typedef enum logic {
		ST_IDLE,
		ST_EVAL
	} pemd_fsm_t;

	typedef struct packed {
		pemd_fsm_t fsm;
		logic ack;
		logic [31:0] rdata;
		logic [11:0] entry;
		logic [51:0] sl_ptr;
		logic [31:0] cap;
		logic [63:0] addr;
		logic fetch;
		logic xflag;
		logic [31:0] result;
		logic [31:0] fault_count;
		logic report;
		logic walk;
		logic [51:0] walk_root;
	} pemd_state_t;

	pemd_state_t s_q;
	pemd_state_t s_d;

	logic access;
	logic commit;
	logic go;
	logic absent;
	logic range_bad;
	logic exec_block;
	logic fault;
	logic report;
	logic [31:0] result_word;
	logic [31:0] read_word;
	logic [31:0] merged;

	pemd_dec_if dec_bus ();

	// =================================================================
	// Decode and check.
	// =================================================================
	// The decoder watches the live entry; software sees its view once a check latches the result.
	pemd_entry_dec u_dec (
		.entry_i(s_q.entry),
		.cap_i(s_q.cap),
		.sl_ptr_i(s_q.sl_ptr),
		.dec_o(dec_bus)
	);

	// The checker judges the latched request against that same entry.
	pemd_req_check u_chk (
		.dec_i(dec_bus),
		.addr_i(s_q.addr),
		.fetch_i(s_q.fetch),
		.xflag_i(s_q.xflag),
		.absent_o(absent),
		.range_o(range_bad),
		.exec_block_o(exec_block),
		.fault_o(fault),
		.report_o(report)
	);

	// =================================================================
	// Bus decode.
	// =================================================================
	// A request is answered one cycle after it appears and takes effect
	// on the edge where the acknowledge is seen, so each write lands once.
	assign access = cyc_i & stb_i & ce_i;
	assign commit = access & s_q.ack;
	assign go = commit & we_i & (adr_i == pemd_pkg::OFF_REQ_CTRL) & sel_i[0]
		& dat_i[pemd_pkg::REQ_GO];

	// Result word packs the decoded view and the outcome of the last check.
	always_comb begin
		result_word = pemd_pkg::WORD_ZERO;
		result_word[0] = 1'b1;
		result_word[1] = fault;
		result_word[2] = report; // see [RULE_14]
		result_word[3] = dec_bus.malformed; // see [RULE_18]
		result_word[4] = absent; // see [RULE_16]
		result_word[5] = range_bad; // see [RULE_13]
		result_word[6] = exec_block; // see [RULE_09]
		result_word[10:8] = dec_bus.ttype;
		result_word[14:12] = dec_bus.levels;
		result_word[21:16] = dec_bus.width;
		result_word[24] = dec_bus.ad_en; // see [RULE_03]
		result_word[25] = dec_bus.exec_en;
		result_word[26] = dec_bus.bypass;
		result_word[27] = dec_bus.fault_dis;
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		case (adr_i)
			pemd_pkg::OFF_ENTRY_CTRL: read_word = {20'h0_0000, s_q.entry};
			pemd_pkg::OFF_SL_PTR_LO: read_word = {s_q.sl_ptr[19:0], 12'h000};
			pemd_pkg::OFF_SL_PTR_HI: read_word = s_q.sl_ptr[51:20];
			pemd_pkg::OFF_EXT_CAP: read_word = s_q.cap;
			pemd_pkg::OFF_REQ_ADDR_LO: read_word = s_q.addr[31:0];
			pemd_pkg::OFF_REQ_ADDR_HI: read_word = s_q.addr[63:32];
			pemd_pkg::OFF_REQ_CTRL: read_word = {29'h0000_0000, s_q.xflag, s_q.fetch, 1'b0};
			pemd_pkg::OFF_RESULT: read_word = s_q.result;
			pemd_pkg::OFF_FAULT_COUNT: read_word = s_q.fault_count;
			default: read_word = pemd_pkg::WORD_ZERO;
		endcase
	end

	// Byte-lane merge for a writable word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] lanes);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (lanes[b]) begin
				res[8*b +: 8] = wdat[8*b +: 8];
			end
		end
		return res;
	endfunction

	// The addressed word as it reads, with the written byte lanes laid over it.
	assign merged = merge(read_word, dat_i, sel_i);

	// =================================================================
	// Next state.
	// =================================================================
	always_comb begin
		s_d = s_q;
		s_d.report = 1'b0;
		s_d.walk = 1'b0;
		// Acknowledge drops the cycle after it is given.
		s_d.ack = access & !s_q.ack;
		if (access & !s_q.ack) begin
			s_d.rdata = read_word;
		end
		if (commit & we_i) begin
			case (adr_i)
				pemd_pkg::OFF_ENTRY_CTRL: begin
					s_d.entry = merged[11:0];
				end
				pemd_pkg::OFF_SL_PTR_LO: begin
					s_d.sl_ptr[19:0] = merged[31:12];
				end
				pemd_pkg::OFF_SL_PTR_HI: begin
					s_d.sl_ptr[51:20] = merged;
				end
				pemd_pkg::OFF_EXT_CAP: begin
					s_d.cap = merged;
				end
				pemd_pkg::OFF_REQ_ADDR_LO: begin
					s_d.addr[31:0] = merged;
				end
				pemd_pkg::OFF_REQ_ADDR_HI: begin
					s_d.addr[63:32] = merged;
				end
				pemd_pkg::OFF_REQ_CTRL: begin
					if (sel_i[0]) begin
						s_d.fetch = dat_i[pemd_pkg::REQ_FETCH];
						s_d.xflag = dat_i[pemd_pkg::REQ_XFLAG];
					end
				end
				default: begin
					s_d.rdata = s_d.rdata;
				end
			endcase
		end
		// Check sequencer: the request fields settle for one cycle before
		// they are judged, which keeps the checker off the write path.
		case (s_q.fsm)
			ST_IDLE: begin
				if (go) begin
					s_d.result = pemd_pkg::WORD_ZERO;
					s_d.fsm = ST_EVAL;
				end
			end
			ST_EVAL: begin
				s_d.result = result_word;
				s_d.report = report; // see [RULE_14] [RULE_15]
				if (report) begin
					s_d.fault_count = s_q.fault_count + pemd_pkg::COUNT_ONE;
				end
				// A clean check of any type but pass-through starts the page walker, rooted at the second-level pointer or, for first level, at zero.
				if (!fault && !dec_bus.bypass) begin
					s_d.walk = 1'b1;
					s_d.walk_root = (dec_bus.ttype == pemd_pkg::TT_FIRST) ? 52'h0_0000_0000_0000
						: s_q.sl_ptr; // see [RULE_06] [RULE_07] [RULE_17]
				end
				s_d.fsm = ST_IDLE;
			end
			default: begin
				s_d.fsm = ST_IDLE;
			end
		endcase
	end

	// =================================================================
	// State register.
	// =================================================================
	// Outside reset, clock enable low freezes every bit, the bus acknowledge included.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.fsm <= ST_IDLE;
			s_q.ack <= 1'b0;
			s_q.rdata <= pemd_pkg::WORD_ZERO;
			s_q.entry <= 12'h000;
			s_q.sl_ptr <= 52'h0_0000_0000_0000;
			s_q.cap <= pemd_pkg::CAP_RESET;
			s_q.addr <= 64'h0000_0000_0000_0000;
			s_q.fetch <= 1'b0;
			s_q.xflag <= 1'b0;
			s_q.result <= pemd_pkg::WORD_ZERO;
			s_q.fault_count <= pemd_pkg::WORD_ZERO;
			s_q.report <= 1'b0;
			s_q.walk <= 1'b0;
			s_q.walk_root <= 52'h0_0000_0000_0000;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// =================================================================
	// Outputs.
	// =================================================================
	assign dat_o = s_q.rdata;
	assign ack_o = s_q.ack;
	assign fault_report_o = s_q.report;
	assign walk_start_o = s_q.walk;
	assign walk_root_o = s_q.walk_root;
endmodule

// ---- pemd_pkg.sv ----
// =====================================================================
// Shared constants for the process table entry mode decoder.
// =====================================================================
package pemd_pkg;

	// =================================================================
	// Register byte offsets on the Wishbone bus.
	// =================================================================
	localparam logic [7:0] OFF_ENTRY_CTRL = 8'h00;
	localparam logic [7:0] OFF_SL_PTR_LO = 8'h04;
	localparam logic [7:0] OFF_SL_PTR_HI = 8'h08;
	localparam logic [7:0] OFF_EXT_CAP = 8'h0C;
	localparam logic [7:0] OFF_REQ_ADDR_LO = 8'h10;
	localparam logic [7:0] OFF_REQ_ADDR_HI = 8'h14;
	localparam logic [7:0] OFF_REQ_CTRL = 8'h18;
	localparam logic [7:0] OFF_RESULT = 8'h1C;
	localparam logic [7:0] OFF_FAULT_COUNT = 8'h20;

	// =================================================================
	// Entry control word field positions.
	// =================================================================
	localparam int POS_PRESENT = 0;
	localparam int POS_FAULT_DIS = 1;
	localparam int POS_WIDTH_LO = 2;
	localparam int POS_EXEC_EN = 5;
	localparam int POS_TYPE_LO = 6;
	localparam int POS_AD_EN = 9;
	localparam int POS_RSV_LO = 10;
	localparam int ENTRY_BITS = 12;

	// =================================================================
	// Extended capability register field positions and reset value.
	// =================================================================
	localparam int CAP_FL = 0;
	localparam int CAP_SL = 1;
	localparam int CAP_SLAD = 2;
	localparam int CAP_NESTING_SUPPORT_CAP = 3;
	localparam int CAP_PT = 4;
	localparam int CAP_WIDTHS_LO = 8;
	localparam int CAP_HAW_LO = 16;
	localparam logic [31:0] CAP_RESET = 32'h0030_0E1F;

	// =================================================================
	// Request control field positions and shared word constants.
	// =================================================================
	localparam int REQ_GO = 0;
	localparam int REQ_FETCH = 1;
	localparam int REQ_XFLAG = 2;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [31:0] COUNT_ONE = 32'h0000_0001;

	// Translation type codes.
	typedef enum logic [2:0] {
		TT_RSVD0 = 3'h0,
		TT_FIRST = 3'h1,
		TT_SECOND = 3'h2,
		TT_NESTED = 3'h3,
		TT_PASS = 3'h4
	} pemd_ttype_t;

	// Address width in bits for a width code; zero for reserved codes.
	function automatic logic [5:0] width_bits(input logic [2:0] code);
		case (code)
			3'h1: width_bits = 6'h27;
			3'h2: width_bits = 6'h30;
			3'h3: width_bits = 6'h39;
			default: width_bits = 6'h00;
		endcase
	endfunction

	// Page walk depth for a width code; zero for reserved codes.
	function automatic logic [2:0] walk_levels(input logic [2:0] code);
		case (code)
			3'h1: walk_levels = 3'h3;
			3'h2: walk_levels = 3'h4;
			3'h3: walk_levels = 3'h5;
			default: walk_levels = 3'h0;
		endcase
	endfunction

endpackage

// ---- pemd_dec_if.sv ----
`timescale 1ns/10ps
// =====================================================================
// Decoded entry fields passed from the decoder to its users.
// =====================================================================
interface pemd_dec_if;
	logic present;
	logic fault_dis;
	logic malformed;
	logic sl_used;
	logic bypass;
	logic ad_en;
	logic exec_en;
	logic [2:0] ttype;
	logic [2:0] levels;
	logic [5:0] width;

	modport dec (output present, fault_dis, malformed, sl_used, bypass, ad_en, exec_en,
		ttype, levels, width);
	modport chk (input present, fault_dis, malformed, sl_used, bypass, ad_en, exec_en,
		ttype, levels, width);
endinterface

// ---- pemd_entry_dec.sv ----
`timescale 1ns/10ps
// =====================================================================
// Combinational decode of the entry control word against capabilities.
// =====================================================================
module pemd_entry_dec (
	input logic [11:0] entry_i,
	input logic [31:0] cap_i,
	input logic [51:0] sl_ptr_i,
	pemd_dec_if.dec dec_o
);
	logic [2:0] tt;
	logic [2:0] wc;
	logic tt_bad;
	logic w_bad;
	logic rsv_bad;
	logic ptr_bad;
	logic [5:0] host_address_width;

	// Type, width and reserved field checks; a present entry is malformed if any fail.
	always_comb begin
		tt = entry_i[pemd_pkg::POS_TYPE_LO +: 3];
		wc = entry_i[pemd_pkg::POS_WIDTH_LO +: 3];
		host_address_width = cap_i[pemd_pkg::CAP_HAW_LO +: 6];
		case (tt)
			pemd_pkg::TT_FIRST: tt_bad = !cap_i[pemd_pkg::CAP_FL]; // see [RULE_05]
			pemd_pkg::TT_SECOND: tt_bad = !cap_i[pemd_pkg::CAP_SL]; // see [RULE_06]
			pemd_pkg::TT_NESTED: tt_bad = !cap_i[pemd_pkg::CAP_NESTING_SUPPORT_CAP]; // see [RULE_07]
			pemd_pkg::TT_PASS: tt_bad = !cap_i[pemd_pkg::CAP_PT]; // see [RULE_08]
			default: tt_bad = 1'b1; // see [RULE_08]
		endcase
		// Code zero is only reserved when second level exists.
		w_bad = (wc == 3'h0) ? cap_i[pemd_pkg::CAP_SL] : (wc[2] == 1'b1); // see [RULE_11]
		// An unsupported width is refused rather than walked.
		if (wc != 3'h0 && wc[2] == 1'b0) begin
			w_bad = w_bad | !cap_i[pemd_pkg::CAP_WIDTHS_LO + 32'(wc)]; // see [RULE_12]
		end
		rsv_bad = (entry_i[pemd_pkg::POS_RSV_LO +: 2] != 2'h0) // see [RULE_01]
			| (entry_i[pemd_pkg::POS_AD_EN]
			& !(cap_i[pemd_pkg::CAP_SL] & cap_i[pemd_pkg::CAP_SLAD])) // see [RULE_02]
			| (entry_i[pemd_pkg::POS_EXEC_EN] & !cap_i[pemd_pkg::CAP_SL]); // see [RULE_09]
		// Pointer bits at or above the host width must be zero.
		ptr_bad = 1'b0;
		for (int i = 12; i < 64; i++) begin
			if (i >= 32'(host_address_width) && sl_ptr_i[i - 12]) begin
				ptr_bad = 1'b1; // see [RULE_17]
			end
		end
	end

	// Drive the decoded view; a non-present entry still decodes every field but is never malformed.
	always_comb begin
		dec_o.present = entry_i[pemd_pkg::POS_PRESENT]; // see [RULE_16]
		dec_o.fault_dis = entry_i[pemd_pkg::POS_FAULT_DIS]; // see [RULE_15]
		dec_o.ttype = tt;
		dec_o.sl_used = (tt == pemd_pkg::TT_SECOND) || (tt == pemd_pkg::TT_NESTED);
		dec_o.bypass = (tt == pemd_pkg::TT_PASS); // see [RULE_08]
		dec_o.malformed = entry_i[pemd_pkg::POS_PRESENT]
			& (tt_bad | w_bad | rsv_bad | ptr_bad); // see [RULE_18]
		// Flag enables are ignored for first level only and pass-through.
		dec_o.ad_en = entry_i[pemd_pkg::POS_AD_EN] & dec_o.sl_used; // see [RULE_03] [RULE_04]
		dec_o.exec_en = entry_i[pemd_pkg::POS_EXEC_EN] & dec_o.sl_used; // see [RULE_04]
		dec_o.width = pemd_pkg::width_bits(wc); // see [RULE_10]
		dec_o.levels = pemd_pkg::walk_levels(wc); // see [RULE_10]
	end
endmodule

// ---- pemd_req_check.sv ----
`timescale 1ns/10ps
// =====================================================================
// Combinational check of one request against the decoded entry.
// =====================================================================
module pemd_req_check (
	pemd_dec_if.chk dec_i,
	input logic [63:0] addr_i,
	input logic fetch_i,
	input logic xflag_i,
	output logic absent_o,
	output logic range_o,
	output logic exec_block_o,
	output logic fault_o,
	output logic report_o
);
	// Fault causes, their sum, and whether it is reported.
	always_comb begin
		absent_o = !dec_i.present; // see [RULE_16]
		range_o = 1'b0;
		for (int i = 0; i < 64; i++) begin
			if (i >= 32'(dec_i.width) && addr_i[i] && dec_i.sl_used) begin
				range_o = 1'b1; // see [RULE_13]
			end
		end
		// Without execute enable any readable address may be fetched from.
		exec_block_o = fetch_i & dec_i.exec_en & !xflag_i; // see [RULE_09]
		fault_o = absent_o | dec_i.malformed | (dec_i.present & (range_o | exec_block_o));
		// Fault disable is honoured even for an absent entry.
		report_o = fault_o & !dec_i.fault_dis; // see [RULE_14] [RULE_15]
	end
endmodule

// ---- pemd_top_asserts.sv ----
`timescale 1ns/10ps
// =====================================================================
// Port checks for the entry mode decoder.
// =====================================================================
module pemd_top_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic fault_report_o,
	input wire logic walk_start_o,
	input wire logic [51:0] walk_root_o
);
	logic go_w;
	// A committed go is the acked write of the launch bit.
	assign go_w = ce_i && ack_o && cyc_i && stb_i && we_i && sel_i[0] && dat_i[0]
		&& (adr_i == pemd_pkg::OFF_REQ_CTRL);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// A fresh request, then a fresh read of an address above the mapped range.
	sequence s_req;
		ce_i && cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_read_high;
		ce_i && cyc_i && stb_i && !we_i && (adr_i > 8'h20) && !ack_o;
	endsequence
	a_ack_follows_req: assert property (s_req |=> ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_unmapped_zero: assert property (s_read_high |=> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_pulse_needs_go: assert property ((walk_start_o || fault_report_o) |-> $past(go_w, 2))
		else $error("event pulse without launch");
	a_walk_or_fault: assert property (!(walk_start_o && fault_report_o))
		else $error("walk launched on faulting check");
	a_fault_single: assert property (fault_report_o |=> !fault_report_o)
		else $error("fault pulse too long");
	a_walk_single: assert property (walk_start_o |=> !walk_start_o)
		else $error("walk pulse too long");
endmodule

// ---- pemd_walk_sink.sv ----
`timescale 1ns/10ps
// =====================================================================
// Table walker stand-in that counts launches and reported faults.
// =====================================================================
module pemd_walk_sink (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic walk_start_i,
	input wire logic fault_report_i,
	input wire logic [51:0] walk_root_i,
	output logic [31:0] walk_count_o,
	output logic [31:0] report_count_o,
	output logic [51:0] root_o
);
	// The root is taken only on a launch, since a walker ignores it otherwise.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			walk_count_o <= 32'h0000_0000;
			report_count_o <= 32'h0000_0000;
			root_o <= 52'h0;
		end else begin
			if (walk_start_i) begin
				walk_count_o <= walk_count_o + 32'h0000_0001;
				root_o <= walk_root_i;
			end
			if (fault_report_i) begin
				report_count_o <= report_count_o + 32'h0000_0001;
			end
		end
	end
endmodule

// ---- pemd_top_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("wrong value %s expected %h seen %h", nm, exp, got); \
	end \
end
// =====================================================================
// Bus driven bench for the entry mode decoder.
// =====================================================================
module pemd_top_tb;
	typedef struct packed {
		logic [31:0] cap;
		logic [11:0] ent;
		logic [31:0] ahi;
		logic [31:0] phi;
		logic [1:0] fx;
		logic [31:0] val;
	} pemd_tcase_t;
	localparam logic [31:0] CR = pemd_pkg::CAP_RESET;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic ce_i = 1'h1;
	logic cyc_i = 1'h0;
	logic stb_i = 1'h0;
	logic we_i = 1'h0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic ack_o;
	logic fault_report_o;
	logic walk_start_o;
	logic [51:0] walk_root_o;
	logic [31:0] walk_count;
	logic [31:0] report_count;
	logic [51:0] root;
	logic [31:0] q;
	logic [31:0] exp_reports = 32'h0000_0000;
	int fail_count = 0;
	int num_checks = 0;
	pemd_tcase_t tc[31];

	pemd_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.fault_report_o(fault_report_o), .walk_start_o(walk_start_o), .walk_root_o(walk_root_o));
	pemd_walk_sink sink (.clk_i(clk_i), .rst_i(rst_i), .walk_start_i(walk_start_o),
		.fault_report_i(fault_report_o), .walk_root_i(walk_root_o), .walk_count_o(walk_count),
		.report_count_o(report_count), .root_o(root));

	// Free running 50 MHz clock.
	always #10 clk_i = ~clk_i;

	// Reset is held three edges, then one idle edge before any request.
	task automatic do_reset();
		rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
	endtask

	// One classic cycle: held until ack is sampled, then released for a cycle.
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		sel_i <= 4'hF;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 40);
		if (n >= 40) fail_count++;
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(a, 1'h0, 32'h0000_0000);
		`CHK(nm, e, q)
	endtask

	// Program an entry, launch a check, compare the masked result and events.
	task automatic run_case(input pemd_tcase_t c);
		logic [31:0] m;
		logic [31:0] w0;
		logic [31:0] r0;
		logic ew;
		m = c.val[3] ? 32'h0000_000F : 32'h0F3F_777F;
		w0 = walk_count;
		r0 = report_count;
		ew = !c.val[1] && !c.val[26];
		wb(pemd_pkg::OFF_EXT_CAP, 1'h1, c.cap);
		wb(pemd_pkg::OFF_ENTRY_CTRL, 1'h1, {20'h0_0000, c.ent});
		wb(pemd_pkg::OFF_SL_PTR_LO, 1'h1, 32'h1234_5FFF);
		wb(pemd_pkg::OFF_SL_PTR_HI, 1'h1, c.phi);
		wb(pemd_pkg::OFF_REQ_ADDR_LO, 1'h1, 32'h0000_1000);
		wb(pemd_pkg::OFF_REQ_ADDR_HI, 1'h1, c.ahi);
		wb(pemd_pkg::OFF_REQ_CTRL, 1'h1, {29'h0000_0000, c.fx, 1'h1});
		wb(pemd_pkg::OFF_RESULT, 1'h0, 32'h0000_0000);
		`CHK("result", c.val, q & m)
		`CHK("walks", {31'h0000_0000, ew}, walk_count - w0)
		`CHK("reports", {31'h0000_0000, c.val[2]}, report_count - r0)
		exp_reports = exp_reports + {31'h0000_0000, c.val[2]};
		if (ew) begin
			`CHK("root", (c.ent[8:6] == 3'h1) ? 52'h0 : {c.phi, 20'h1_2345}, root)
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The whole run is some 785 cycles; the limit leaves ample margin.
	initial begin
		#400000;
		fail_count++;
		conclude();
	end

	// Case table: capability, entry, address high, pointer high, fetch and flag, result.
	initial begin
		tc = '{
			'{CR, 12'h000, 32'h0, 32'h0, 2'h0, 32'h0000_0017},
			'{CR, 12'h002, 32'h0, 32'h0, 2'h0, 32'h0800_0013},
			'{CR, 12'h2A9, 32'h0, 32'h0, 2'h1, 32'h0330_4247},
			'{CR, 12'h2A9, 32'h0, 32'h0, 2'h3, 32'h0330_4201},
			'{CR, 12'h289, 32'h0, 32'h0, 2'h1, 32'h0130_4201},
			'{CR, 12'h089, 32'h0001_0000, 32'h0, 2'h0, 32'h0030_4227},
			'{CR, 12'h089, 32'h0000_FFFF, 32'h0000_ABCD, 2'h0, 32'h0030_4201},
			'{CR, 12'h269, 32'h0001_0000, 32'h0, 2'h1, 32'h0030_4101},
			'{CR, 12'h329, 32'h0, 32'h0, 2'h1, 32'h0430_4401},
			'{CR, 12'h0CD, 32'h0, 32'h0, 2'h0, 32'h0039_5301},
			'{CR, 12'h085, 32'h0000_0080, 32'h0, 2'h0, 32'h0027_3227},
			'{CR, 12'h009, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h149, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h189, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h1C9, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h081, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h091, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h095, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h099, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h09D, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h489, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h889, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h00B, 32'h0, 32'h0, 2'h0, 32'h0000_000B},
			'{32'h0030_0E1E, 12'h049, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{32'h0030_0E1D, 12'h089, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{32'h0030_0E17, 12'h0C9, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{32'h0030_0E0F, 12'h109, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{32'h0030_0E1B, 12'h289, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{32'h0030_0E1D, 12'h069, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{32'h0030_061F, 12'h08D, 32'h0, 32'h0, 2'h0, 32'h0000_000F},
			'{CR, 12'h089, 32'h0, 32'h0001_0000, 2'h0, 32'h0000_000F}
		};
	end

	// Main sequence: registers, decode table, then a reset in mid-run.
	initial begin
		do_reset();
		rchk(pemd_pkg::OFF_EXT_CAP, CR, "cap reset");
		rchk(pemd_pkg::OFF_ENTRY_CTRL, 32'h0000_0000, "entry reset");
		rchk(pemd_pkg::OFF_FAULT_COUNT, 32'h0000_0000, "count reset");
		rchk(8'h24, 32'h0000_0000, "unmapped");
		wb(pemd_pkg::OFF_SL_PTR_LO, 1'h1, 32'h1234_5FFF);
		rchk(pemd_pkg::OFF_SL_PTR_LO, 32'h1234_5000, "pointer low");
		wb(pemd_pkg::OFF_RESULT, 1'h1, 32'hFFFF_FFFF);
		rchk(pemd_pkg::OFF_RESULT, 32'h0000_0000, "result read only");
		$display("test registers done");
		foreach (tc[i]) begin
			run_case(tc[i]);
		end
		rchk(pemd_pkg::OFF_FAULT_COUNT, exp_reports, "fault count");
		$display("test decode table done");
		do_reset();
		rchk(pemd_pkg::OFF_ENTRY_CTRL, 32'h0000_0000, "entry after reset");
		rchk(pemd_pkg::OFF_EXT_CAP, CR, "cap after reset");
		$display("test second reset done");
		conclude();
	end
endmodule

bind pemd_top pemd_top_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .fault_report_o(fault_report_o), .walk_start_o(walk_start_o),
	.walk_root_o(walk_root_o));
